// ==== rtl/lcd_cmd_defines.svh ====
// Offsets, opcodes, field positions and timing counts of the LCD command link
`ifndef LCD_CMD_DEFINES_SVH
`define LCD_CMD_DEFINES_SVH
// ****************************************************
// Register select values
// ****************************************************
`define RS_CMD        2'h0
`define RS_DATA       2'h1
// ****************************************************
// Opcodes and prefix patterns
// ****************************************************
`define OP_INIT_MSB   8'h16
`define OP_INIT_LSB   8'h03
`define OP_REFRESH    8'hf0
`define MASK_MODE     8'hf0
`define PAT_MODE      8'h50
`define MASK_OSC      8'hf8
`define PAT_OSC       8'h18
`define MASK_BIAS     8'hfc
`define PAT_BIAS      8'h04
`define MASK_FRAME    8'he0
`define PAT_FRAME     8'h20
`define MASK_PTR      8'hc0
`define PAT_PTR       8'h80
// ****************************************************
// Field positions
// ****************************************************
`define BIT_BPS       3
`define BIT_INV       2
`define BIT_PD        1
`define BIT_EN        0
`define BIT_EFR       2
`define BIT_COE       1
`define BIT_OSC       0
// ****************************************************
// Host register offsets and fields
// ****************************************************
`define REG_TX        8'h00
`define REG_STATUS    8'h04
`define TX_RS_LSB     8
`define ST_BUSY       0
`define ST_CAL_WIN    1
`define ST_REFRESHED  2
`define ST_DISP_ON    3
// ****************************************************
// Timing
// ****************************************************
`define CLK_HZ        25000000
`define CAL_TIME_MS   30
`define CAL_CYCLES    ((`CAL_TIME_MS * `CLK_HZ) / 1000)
`define CAL_CNT_W     20
`endif

// ==== rtl/lcd_cmd_host.sv ====
// Command host: APB registers that send checked bytes over the LCD command link
`include "lcd_cmd_defines.svh"
module lcd_cmd_host #(
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Command link
  lcd_link_if.host         LINK
);
  localparam int CNT_W = `CAL_CNT_W;

  if (CAL_CYCLES < 1 || CAL_CYCLES >= (2 ** CNT_W)) begin : g_bad_cal
    $error("CAL_CYCLES out of range");
  end

  // ****************************************************
  // Request decode and legality
  // ****************************************************
  logic                 valid_r;
  logic [1:0]           rs_r;
  logic [7:0]           byte_r;
  logic                 refreshed_r;
  logic                 disp_on_r;
  logic                 bps_set_r;
  logic                 bps_r;
  logic                 half_r;
  logic [CNT_W-1:0]     win_r;
  logic                 access;
  logic                 tx_wr;
  logic [1:0]           w_rs;
  logic [7:0]           w_b;
  lcd_cmd_pkg::cmd_type w_cmd;
  logic                 illegal;
  logic                 send;
  logic                 is_init;

  assign access  = PSEL & PENABLE & ~PREADY;
  assign tx_wr   = access & PWRITE & (PADDR == `REG_TX);
  assign w_rs    = PWDATA[`TX_RS_LSB+1:`TX_RS_LSB];
  assign w_b     = PWDATA[7:0];
  assign w_cmd   = lcd_cmd_pkg::classify(w_rs, w_b);
  assign illegal = (w_cmd == lcd_cmd_pkg::CMD_NONE) // [RULE_01]
    | ((w_cmd == lcd_cmd_pkg::CMD_MODE) & w_b[`BIT_EN] & ~disp_on_r
       & (~refreshed_r | ~bps_set_r | (w_b[`BIT_BPS] != bps_r))) // [RULE_07] [RULE_12]
    | ((w_cmd == lcd_cmd_pkg::CMD_MODE) & w_b[`BIT_PD]
       & (disp_on_r | w_b[`BIT_EN] | (win_r != '0))); // [RULE_17] [RULE_10]
  assign send    = tx_wr & ~valid_r & ~illegal;
  assign is_init = send & (w_cmd == lcd_cmd_pkg::CMD_INIT_LSB) & half_r; // [RULE_05]

  // ****************************************************
  // APB answer
  // ****************************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
      if (access) begin
        if (tx_wr) begin
          PREADY  <= ~valid_r;
          PSLVERR <= ~valid_r & illegal;
        end else if (~PWRITE && PADDR == `REG_STATUS) begin
          PREADY                <= 1'b1;
          PRDATA[`ST_BUSY]      <= valid_r;
          PRDATA[`ST_CAL_WIN]   <= (win_r != '0);
          PRDATA[`ST_REFRESHED] <= refreshed_r;
          PRDATA[`ST_DISP_ON]   <= disp_on_r;
        end else begin
          PREADY  <= 1'b1;
          PSLVERR <= 1'b1;
        end
      end
    end
  end

  // ****************************************************
  // Link driver
  // ****************************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      valid_r <= 1'b0;
      rs_r    <= 2'h0;
      byte_r  <= 8'h00;
    end else if (send) begin
      valid_r <= 1'b1; // [RULE_02]
      rs_r    <= w_rs;
      byte_r  <= w_b;
    end else if (LINK.ready) begin
      valid_r <= 1'b0;
    end
  end

  assign LINK.valid           = valid_r;
  assign LINK.register_select = rs_r;
  assign LINK.data_byte       = byte_r;

  // ****************************************************
  // Shadow of device state
  // ****************************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST || is_init) begin
      half_r      <= 1'b0;
      refreshed_r <= 1'b0;
      disp_on_r   <= 1'b0;
      bps_set_r   <= 1'b0;
      bps_r       <= 1'b0;
      win_r       <= '0;
    end else begin
      if (send) begin
        half_r <= (w_cmd == lcd_cmd_pkg::CMD_INIT_MSB); // [RULE_05]
      end
      if (send && w_cmd == lcd_cmd_pkg::CMD_REFRESH) begin
        refreshed_r <= 1'b1; // [RULE_07]
        win_r       <= CNT_W'(CAL_CYCLES);
      end else if (win_r != '0) begin
        win_r <= win_r - CNT_W'(1); // [RULE_10]
      end
      if (send && w_cmd == lcd_cmd_pkg::CMD_MODE) begin
        disp_on_r <= w_b[`BIT_EN];
        bps_r     <= w_b[`BIT_BPS];
        bps_set_r <= bps_set_r | ~w_b[`BIT_EN]; // [RULE_12]
      end
    end
  end
endmodule : lcd_cmd_host

// ==== rtl/lcd_cmd_pkg.sv ====
// Types and the shared command classifier of the LCD command link
`include "lcd_cmd_defines.svh"
package lcd_cmd_pkg;
  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [3:0] {
    CMD_NONE, CMD_INIT_MSB, CMD_INIT_LSB, CMD_REFRESH, CMD_MODE,
    CMD_OSC, CMD_BIAS, CMD_FRAME, CMD_POINTER, CMD_RAM
  } cmd_type;

  typedef enum logic [1:0] {
    REF_IDLE = 2'h0,
    REF_PEND = 2'h1,
    REF_RUN  = 2'h3
  } refresh_state_type;

  // ****************************************************
  // Classify one byte by register select and prefix
  // ****************************************************
  function automatic cmd_type classify(input logic [1:0] rs, input logic [7:0] b);
    cmd_type c;
    c = CMD_NONE;
    if (rs == `RS_DATA) begin
      c = CMD_RAM;
    end else if (rs == `RS_CMD) begin
      if (b == `OP_INIT_MSB) c = CMD_INIT_MSB;
      else if (b == `OP_INIT_LSB) c = CMD_INIT_LSB;
      else if (b == `OP_REFRESH) c = CMD_REFRESH;
      else if ((b & `MASK_MODE) == `PAT_MODE) c = CMD_MODE;
      else if ((b & `MASK_OSC) == `PAT_OSC) c = CMD_OSC;
      else if ((b & `MASK_BIAS) == `PAT_BIAS) c = CMD_BIAS;
      else if ((b & `MASK_FRAME) == `PAT_FRAME) c = CMD_FRAME;
      else if ((b & `MASK_PTR) == `PAT_PTR) c = CMD_POINTER;
    end
    return c;
  endfunction : classify
endpackage : lcd_cmd_pkg

// ==== rtl/lcd_driver_command_decoder.sv ====
// LCD driver command decoder: the device end of the command link
// How it works
// [RULE_01] Only eight command kinds are acted on
// [RULE_02] Select 00 command, 01 display data
// [RULE_03] Commands decoded by their fixed prefix bits
// [RULE_04] Full initialize sequence resets the whole chip
// [RULE_05] Initialize needs both bytes, in order
// [RULE_06] Refresh byte reloads calibration from cells
// [RULE_07] Host refreshes calibration before display enable
// [RULE_08] Refresh ends within 30 ms on clock
// [RULE_09] Refresh waits pending while no clock
// [RULE_10] Host avoids power-down during refresh
// [RULE_11] Mode byte sets swap, inversion, power, enable
// [RULE_12] Host sets swap before enabling display
// [RULE_13] Inversion bit picks line or frame scheme
// [RULE_14] Frame scheme balances over two frames
// [RULE_15] Power-down grounds outputs, stops oscillator
// [RULE_16] Display disabled grounds all outputs
// [RULE_17] Host disables display before power-down
// [RULE_18] Clock source and frequency select bits
// [RULE_19] Reset or initialize clears all settings
`include "lcd_cmd_defines.svh"
module lcd_driver_command_decoder #(
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  // Command link
  lcd_link_if.device      LINK,
  // Clock and timing inputs
  input  wire logic       CLOCK_PRESENT,
  input  wire logic       FRAME_TICK,
  input  wire logic       LINE_TICK,
  // Mode settings
  output logic            BACKPLANE_SWAP_SEL,
  output logic            INVERSION_SCHEME_SEL,
  output logic            LOW_POWER_BIT,
  output logic            DISPLAY_ENABLE,
  // Oscillator settings
  output logic            EXT_CLOCK_FREQ_SEL,
  output logic            CLOCK_PIN_OUTPUT_ON,
  output logic            CLOCK_SOURCE_SEL,
  output logic            CLOCK_PIN_OE,
  output logic            OSC_RUNNING,
  // Bias and frame
  output logic [1:0]      BIAS_FIELD,
  output logic [4:0]      FRAME_DIVIDER_FIELD,
  // Display RAM
  output logic [5:0]      RAM_POINTER_FIELD,
  output logic            RAM_WRITE,
  output logic [5:0]      RAM_ADDR,
  output logic [7:0]      RAM_DATA,
  // Drive status
  output logic            OUTPUTS_GROUNDED,
  output logic            DRIVE_POLARITY,
  // Calibration and chip reset
  output logic            CAL_BUSY,
  output logic            CAL_RELOAD,
  output logic            CAL_DONE,
  output logic            CHIP_INIT
);
  localparam int CNT_W = `CAL_CNT_W;

  // ****************************************************
  // Elaboration checks
  // ****************************************************
  if (CAL_CYCLES < 1 || CAL_CYCLES >= (2 ** CNT_W)) begin : g_bad_cal
    $error("CAL_CYCLES out of range");
  end

  // ****************************************************
  // Byte intake
  // ****************************************************
  lcd_cmd_pkg::cmd_type cmd;
  logic                 take;
  logic [7:0]           b;
  logic                 init_half_r;
  logic                 chip_init;
  logic                 ready_r;

  assign b         = LINK.data_byte;
  assign take      = LINK.valid & ready_r;
  assign cmd       = take ? lcd_cmd_pkg::classify(LINK.register_select, b)
                          : lcd_cmd_pkg::CMD_NONE; // [RULE_01] [RULE_02] [RULE_03]
  assign chip_init = (cmd == lcd_cmd_pkg::CMD_INIT_LSB) & init_half_r; // [RULE_05]
  assign LINK.ready = ready_r;

  always_ff @(posedge CLK_SYS) begin
    ready_r <= ~RST;
  end

  // Second initialize byte only counts straight after the first
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      init_half_r <= 1'b0;
    end else if (take) begin
      init_half_r <= (cmd == lcd_cmd_pkg::CMD_INIT_MSB); // [RULE_05]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CHIP_INIT <= 1'b0;
    end else begin
      CHIP_INIT <= chip_init; // [RULE_04]
    end
  end

  // ****************************************************
  // Mode, oscillator, bias and frame settings
  // ****************************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST || chip_init) begin
      BACKPLANE_SWAP_SEL   <= 1'b0; // [RULE_19] [RULE_04]
      INVERSION_SCHEME_SEL <= 1'b0;
      LOW_POWER_BIT        <= 1'b0;
      DISPLAY_ENABLE       <= 1'b0;
    end else if (cmd == lcd_cmd_pkg::CMD_MODE) begin
      BACKPLANE_SWAP_SEL   <= b[`BIT_BPS]; // [RULE_11]
      INVERSION_SCHEME_SEL <= b[`BIT_INV]; // [RULE_13]
      LOW_POWER_BIT        <= b[`BIT_PD];
      DISPLAY_ENABLE       <= b[`BIT_EN];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || chip_init) begin
      EXT_CLOCK_FREQ_SEL  <= 1'b0; // [RULE_19]
      CLOCK_PIN_OUTPUT_ON <= 1'b0;
      CLOCK_SOURCE_SEL    <= 1'b0;
    end else if (cmd == lcd_cmd_pkg::CMD_OSC) begin
      EXT_CLOCK_FREQ_SEL  <= b[`BIT_EFR]; // [RULE_18]
      CLOCK_PIN_OUTPUT_ON <= b[`BIT_COE];
      CLOCK_SOURCE_SEL    <= b[`BIT_OSC]; // [RULE_18]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || chip_init) begin
      BIAS_FIELD          <= 2'h0;
      FRAME_DIVIDER_FIELD <= 5'h00;
    end else if (cmd == lcd_cmd_pkg::CMD_BIAS) begin
      BIAS_FIELD          <= b[1:0]; // [RULE_03]
    end else if (cmd == lcd_cmd_pkg::CMD_FRAME) begin
      FRAME_DIVIDER_FIELD <= b[4:0]; // [RULE_03]
    end
  end

  // ****************************************************
  // Output drive and clock pin
  // ****************************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      OUTPUTS_GROUNDED <= 1'b1;
      OSC_RUNNING      <= 1'b0;
      CLOCK_PIN_OE     <= 1'b0;
    end else begin
      OUTPUTS_GROUNDED <= LOW_POWER_BIT | ~DISPLAY_ENABLE; // [RULE_15] [RULE_16]
      OSC_RUNNING      <= ~LOW_POWER_BIT & ~CLOCK_SOURCE_SEL; // [RULE_15] [RULE_18]
      CLOCK_PIN_OE     <= CLOCK_PIN_OUTPUT_ON & ~CLOCK_SOURCE_SEL & ~LOW_POWER_BIT;
    end
  end

  // Polarity flips per line in scheme A, per frame in scheme B
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DRIVE_POLARITY <= 1'b0;
    end else if (INVERSION_SCHEME_SEL ? FRAME_TICK : LINE_TICK) begin
      DRIVE_POLARITY <= ~DRIVE_POLARITY; // [RULE_13] [RULE_14]
    end
  end

  // ****************************************************
  // Display RAM writes with auto-increment
  // ****************************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST || chip_init) begin
      RAM_POINTER_FIELD <= 6'h00;
      RAM_WRITE         <= 1'b0;
      RAM_ADDR          <= 6'h00;
      RAM_DATA          <= 8'h00;
    end else begin
      RAM_WRITE <= (cmd == lcd_cmd_pkg::CMD_RAM);
      if (cmd == lcd_cmd_pkg::CMD_POINTER) begin
        RAM_POINTER_FIELD <= b[5:0]; // [RULE_03]
      end else if (cmd == lcd_cmd_pkg::CMD_RAM) begin
        RAM_ADDR          <= RAM_POINTER_FIELD; // [RULE_02]
        RAM_DATA          <= b;
        RAM_POINTER_FIELD <= RAM_POINTER_FIELD + 6'h01;
      end
    end
  end

  // ****************************************************
  // External clock presence synchroniser
  // ****************************************************
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic ext_present_r;
  logic clock_ok;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sync1_r       <= 1'b0;
      sync2_r       <= 1'b0;
      sync3_r       <= 1'b0;
      ext_present_r <= 1'b0;
    end else begin
      sync1_r <= CLOCK_PRESENT;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        ext_present_r <= sync3_r;
      end
    end
  end

  assign clock_ok = CLOCK_SOURCE_SEL ? ext_present_r : ~LOW_POWER_BIT; // [RULE_09]

  // ****************************************************
  // Calibration refresh
  // ****************************************************
  lcd_cmd_pkg::refresh_state_type ref_state_r;
  logic [CNT_W-1:0]               cal_cnt_r;
  logic                           ref_req;

  assign ref_req = (cmd == lcd_cmd_pkg::CMD_REFRESH);

  always_ff @(posedge CLK_SYS) begin
    if (RST || chip_init) begin
      ref_state_r <= lcd_cmd_pkg::REF_IDLE;
      cal_cnt_r   <= '0;
      CAL_RELOAD  <= 1'b0;
      CAL_DONE    <= 1'b0;
      CAL_BUSY    <= 1'b0;
    end else begin
      CAL_RELOAD <= 1'b0;
      CAL_DONE   <= 1'b0;
      case (ref_state_r)
        lcd_cmd_pkg::REF_IDLE: begin
          if (ref_req) begin
            ref_state_r <= lcd_cmd_pkg::REF_PEND; // [RULE_06]
            CAL_BUSY    <= 1'b1;
          end
        end
        lcd_cmd_pkg::REF_PEND: begin
          if (clock_ok) begin
            ref_state_r <= lcd_cmd_pkg::REF_RUN; // [RULE_09]
            cal_cnt_r   <= CNT_W'(CAL_CYCLES - 1);
            CAL_RELOAD  <= 1'b1; // [RULE_06]
          end
        end
        lcd_cmd_pkg::REF_RUN: begin
          if (ref_req) begin
            cal_cnt_r  <= CNT_W'(CAL_CYCLES - 1); // [RULE_06]
            CAL_RELOAD <= 1'b1;
          end else if (cal_cnt_r == '0) begin
            ref_state_r <= lcd_cmd_pkg::REF_IDLE; // [RULE_08]
            CAL_DONE    <= 1'b1;
            CAL_BUSY    <= 1'b0;
          end else if (clock_ok) begin
            cal_cnt_r <= cal_cnt_r - CNT_W'(1); // [RULE_08]
          end
        end
        default: begin
          ref_state_r <= lcd_cmd_pkg::REF_IDLE;
        end
      endcase
    end
  end
endmodule : lcd_driver_command_decoder

// ==== rtl/lcd_link_if.sv ====
// Byte link between the command host and the LCD command decoder
interface lcd_link_if;
  logic       valid;
  logic       ready;
  logic [1:0] register_select;
  logic [7:0] data_byte;

  modport device (input valid, input register_select, input data_byte, output ready);
  modport host   (output valid, output register_select, output data_byte, input ready);
endinterface : lcd_link_if

// ==== tb/lcd_cmd_asserts.sv ====
// Concurrent checks on the LCD command link and the decoder outputs
module lcd_cmd_asserts #(
  parameter int CAL_CYCLES = 20
) (
  // Clock and reset
  input logic       CLK_SYS,
  input logic       RST,
  // Link
  input logic       valid,
  input logic       ready,
  input logic [1:0] register_select,
  input logic [7:0] data_byte,
  // Timing inputs
  input logic       LINE_TICK,
  input logic       FRAME_TICK,
  // Decoder outputs
  input logic       BACKPLANE_SWAP_SEL,
  input logic       INVERSION_SCHEME_SEL,
  input logic       LOW_POWER_BIT,
  input logic       DISPLAY_ENABLE,
  input logic       EXT_CLOCK_FREQ_SEL,
  input logic       CLOCK_PIN_OUTPUT_ON,
  input logic       CLOCK_SOURCE_SEL,
  input logic       OSC_RUNNING,
  input logic [1:0] BIAS_FIELD,
  input logic [5:0] RAM_POINTER_FIELD,
  input logic       RAM_WRITE,
  input logic [5:0] RAM_ADDR,
  input logic [7:0] RAM_DATA,
  input logic       OUTPUTS_GROUNDED,
  input logic       DRIVE_POLARITY,
  input logic       CAL_BUSY,
  input logic       CAL_RELOAD,
  input logic       CAL_DONE,
  input logic       CHIP_INIT
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL_WAIT = CAL_CYCLES + 4;
  // ****************************************************
  // Helper logic
  // ****************************************************
  logic       cmd_take;
  logic       msb_seen_r;
  logic [3:0] init_age_r;
  assign cmd_take = valid && ready && register_select == 2'h0;
  always_ff @(posedge CLK_SYS) begin
    if (RST) msb_seen_r <= 1'b0;
    else if (valid && ready) msb_seen_r <= cmd_take && data_byte == 8'h16;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) init_age_r <= 4'hf;
    else if (cmd_take && msb_seen_r && data_byte == 8'h03) init_age_r <= 4'h0;
    else if (init_age_r != 4'hf) init_age_r <= init_age_r + 4'h1;
  end
  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_ref_take;
    cmd_take && data_byte == 8'hf0;
  endsequence
  sequence s_cal_end;
    ##[1:CAL_WAIT] CAL_DONE;
  endsequence
  AST_MODE_BITS: assert property (cmd_take && data_byte[7:4] == 4'h5 |=>
    {BACKPLANE_SWAP_SEL, INVERSION_SCHEME_SEL, LOW_POWER_BIT, DISPLAY_ENABLE} == $past(data_byte[3:0]))
    else $error("mode bits differ from mode byte");
  AST_OSC_BITS: assert property (cmd_take && data_byte[7:3] == 5'h03 |=>
    {EXT_CLOCK_FREQ_SEL, CLOCK_PIN_OUTPUT_ON, CLOCK_SOURCE_SEL} == $past(data_byte[2:0]))
    else $error("oscillator bits differ from byte");
  AST_BIAS: assert property (cmd_take && data_byte[7:2] == 6'h01 |=>
    BIAS_FIELD == $past(data_byte[1:0])) else $error("bias field wrong");
  AST_RAM_WRITE: assert property (valid && ready && register_select == 2'h1 |=>
    RAM_WRITE && RAM_DATA == $past(data_byte) && RAM_ADDR == $past(RAM_POINTER_FIELD)
    && RAM_POINTER_FIELD == $past(RAM_POINTER_FIELD) + 6'h01) else $error("ram write wrong");
  AST_GROUNDED: assert property (OUTPUTS_GROUNDED ==
    $past(LOW_POWER_BIT || !DISPLAY_ENABLE)) else $error("grounding wrong");
  AST_OSC_RUN: assert property (!$past(RST) |-> OSC_RUNNING ==
    $past(!LOW_POWER_BIT && !CLOCK_SOURCE_SEL)) else $error("oscillator run wrong");
  AST_REF_BUSY: assert property (s_ref_take |=> CAL_BUSY)
    else $error("refresh not busy");
  AST_CAL_END: assert property (CAL_RELOAD |-> s_cal_end)
    else $error("refresh too long");
  AST_INIT_PAIR: assert property (CHIP_INIT |-> init_age_r <= 4'h3)
    else $error("chip init without pair");
  AST_POL_TOGGLE: assert property ((INVERSION_SCHEME_SEL ? FRAME_TICK : LINE_TICK) |=>
    $changed(DRIVE_POLARITY)) else $error("polarity did not toggle");
  AST_POL_HOLD: assert property (!LINE_TICK && !FRAME_TICK |=> $stable(DRIVE_POLARITY))
    else $error("polarity moved without tick");
endmodule : lcd_cmd_asserts

// ==== tb/lcd_driver_command_decoder_tb_top.sv ====
// Testbench top: APB host and command decoder joined by the command link
module lcd_driver_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************
  // Signals
  // ****************************************************
  localparam int CAL = 20;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, clock_present;
  logic        line_tick, frame_tick, backplane_swap_sel, inversion_scheme_sel, pd, en, ext_clock_freq_sel, clock_pin_output_on, osc, oe, osc_run;
  logic        ram_wr, gnd, pol, busy, reload, done, cinit, errv;
  logic [1:0]  bias;
  logic [3:0]  tick_cnt;
  logic [4:0]  fd;
  logic [5:0]  ptr, raddr;
  logic [7:0]  paddr, rdata;
  logic [31:0] pwdata, prdata, rdv;
  logic [9:0]  bad [6];
  int          mismatches, total_checks, dones, inits, wrs, d0;
  wire  [13:0] set_v = {backplane_swap_sel, inversion_scheme_sel, pd, en, ext_clock_freq_sel, clock_pin_output_on, osc, bias, fd};
  lcd_link_if i_lcd_link_if ();
  lcd_driver_command_decoder #(.CAL_CYCLES(CAL)) i_lcd_driver_command_decoder (
    .CLK_SYS(clk_sys), .RST(rst), .LINK(i_lcd_link_if), .CLOCK_PRESENT(clock_present),
    .FRAME_TICK(frame_tick), .LINE_TICK(line_tick), .BACKPLANE_SWAP_SEL(backplane_swap_sel),
    .INVERSION_SCHEME_SEL(inversion_scheme_sel), .LOW_POWER_BIT(pd), .DISPLAY_ENABLE(en),
    .EXT_CLOCK_FREQ_SEL(ext_clock_freq_sel), .CLOCK_PIN_OUTPUT_ON(clock_pin_output_on), .CLOCK_SOURCE_SEL(osc),
    .CLOCK_PIN_OE(oe), .OSC_RUNNING(osc_run), .BIAS_FIELD(bias), .FRAME_DIVIDER_FIELD(fd),
    .RAM_POINTER_FIELD(ptr), .RAM_WRITE(ram_wr), .RAM_ADDR(raddr), .RAM_DATA(rdata),
    .OUTPUTS_GROUNDED(gnd), .DRIVE_POLARITY(pol), .CAL_BUSY(busy), .CAL_RELOAD(reload),
    .CAL_DONE(done), .CHIP_INIT(cinit));
  lcd_cmd_host #(.CAL_CYCLES(CAL)) i_lcd_cmd_host (
    .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINK(i_lcd_link_if));
  lcd_cmd_asserts #(.CAL_CYCLES(CAL)) i_lcd_cmd_asserts (
    .CLK_SYS(clk_sys), .RST(rst), .valid(i_lcd_link_if.valid), .ready(i_lcd_link_if.ready),
    .register_select(i_lcd_link_if.register_select), .data_byte(i_lcd_link_if.data_byte),
    .LINE_TICK(line_tick), .FRAME_TICK(frame_tick), .BACKPLANE_SWAP_SEL(backplane_swap_sel),
    .INVERSION_SCHEME_SEL(inversion_scheme_sel), .LOW_POWER_BIT(pd), .DISPLAY_ENABLE(en),
    .EXT_CLOCK_FREQ_SEL(ext_clock_freq_sel), .CLOCK_PIN_OUTPUT_ON(clock_pin_output_on), .CLOCK_SOURCE_SEL(osc),
    .OSC_RUNNING(osc_run), .BIAS_FIELD(bias), .RAM_POINTER_FIELD(ptr), .RAM_WRITE(ram_wr),
    .RAM_ADDR(raddr), .RAM_DATA(rdata), .OUTPUTS_GROUNDED(gnd), .DRIVE_POLARITY(pol),
    .CAL_BUSY(busy), .CAL_RELOAD(reload), .CAL_DONE(done), .CHIP_INIT(cinit));
  // ****************************************************
  // Clock, ticks and monitors
  // ****************************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tick_cnt <= tick_cnt + 4'h1;
    line_tick <= tick_cnt[1:0] == 2'h1;
    frame_tick <= tick_cnt == 4'h8;
  end
  always @(negedge clk_sys) begin
    if (done === 1'b1) dones++;
    if (cinit === 1'b1) inits++;
    if (ram_wr === 1'b1) wrs++;
  end
  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic send(input logic [1:0] rs, input logic [7:0] b, input logic e);
    apb(1'b1, 8'h00, {22'h0, rs, b});
    chk(errv, e);
    repeat (2) @(posedge clk_sys);
  endtask : send
  task automatic wait_done();
    for (int n = 0; n < CAL + 10 && dones == d0; n++) @(posedge clk_sys);
  endtask : wait_done
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, clock_present} = '1;
    {psel, penable, pwrite, paddr, pwdata, clock_present, line_tick, frame_tick} = '0;
    tick_cnt = 4'h0;
    bad = '{10'h000, 10'h008, 10'h040, 10'h255, 10'h300, 10'h05f};
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({set_v, gnd}, {14'h0, 1'b1});
    $display("test reset done");
    d0 = dones;
    send(2'h0, 8'hf0, 1'b0);
    chk(busy, 1'b1);
    wait_done();
    chk(dones - d0, 1);
    $display("test refresh done");
    send(2'h0, 8'h58, 1'b0);
    send(2'h0, 8'h5d, 1'b0);
    chk({set_v, gnd}, {14'h3400, 1'b0});
    for (int i = 0; i < 6; i++) send(bad[i][9:8], bad[i][7:0], 1'b1);
    chk(set_v, 14'h3400);
    apb(1'b0, 8'h08, 32'h0);
    chk(errv, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdv[3], 1'b1);
    $display("test mode and refusals done");
    send(2'h0, 8'h1e, 1'b0);
    send(2'h0, 8'h06, 1'b0);
    send(2'h0, 8'h35, 1'b0);
    send(2'h0, 8'hbe, 1'b0);
    chk({set_v, oe, osc_run, ptr}, {14'h3755, 2'b11, 6'h3e});
    for (int i = 1; i < 4; i++) send(2'h1, 8'h11 * i, 1'b0);
    chk({ptr, raddr, rdata, wrs}, {6'h01, 6'h00, 8'h33, 32'd3});
    $display("test fields and ram done");
    send(2'h0, 8'h5c, 1'b0);
    send(2'h0, 8'h5e, 1'b0);
    chk({set_v, gnd, osc_run, oe}, {14'h3b55, 3'b100});
    $display("test power down done");
    send(2'h0, 8'h16, 1'b0);
    send(2'h0, 8'h06, 1'b0);
    send(2'h0, 8'h03, 1'b0);
    chk({inits, pd}, {32'd0, 1'b1});
    send(2'h0, 8'h16, 1'b0);
    send(2'h0, 8'h03, 1'b0);
    chk({inits, set_v, gnd, ptr}, {32'd1, 14'h0, 1'b1, 6'h0});
    send(2'h0, 8'h50, 1'b0);
    send(2'h0, 8'h51, 1'b1);
    $display("test initialize done");
    send(2'h0, 8'h19, 1'b0);
    d0 = dones;
    send(2'h0, 8'hf0, 1'b0);
    send(2'h0, 8'h52, 1'b1);
    repeat (30) @(posedge clk_sys);
    chk({busy, dones - d0}, {1'b1, 32'd0});
    clock_present <= 1'b1;
    wait_done();
    chk(dones - d0, 1);
    $display("test pending refresh done");
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end
endmodule : lcd_driver_command_decoder_tb_top
